// [hw/pgs_map.svh]
// Register offsets, field positions and reset values for the power-good register bank
`ifndef PGS_MAP_SVH
`define PGS_MAP_SVH
`define PGS_ADDR_VSEL3 8'h35
`define PGS_ADDR_STATUS 8'h36
`define PGS_ADDR_ROUTE 8'h37
`define PGS_BIT_SUPPLY 3
`define PGS_BIT_BATT 2
`define PGS_BIT_BOOST 1
`define PGS_BIT_REG1 0
`define PGS_FIELD_MSB 3
`define PGS_VSEL3_RST_DEF 4'h2
`define PGS_ROUTE_RST_DEF 4'h9
`define PGS_ROUTE_FIXED_MASK 4'h9
`define PGS_MV_WIDTH 13
`endif

// [hw/pgs_pkg.sv]
// Types shared by the power-good register bank
package pgs_pkg;
    // Register access request from the serial front end
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pgs_req_t;
    // Live analog good indications
    typedef struct packed {
        logic supply;
        logic batt;
        logic boost;
        logic reg1;
    } pgs_good_t;
    // Regulator output mode
    typedef enum logic { PGS_MODE_LDO, PGS_MODE_SWITCH } pgs_mode_t;
endpackage

// [hw/pgs_vdecode.sv]
// Voltage code to millivolt decoder for a linear regulator channel
`timescale 1ns/10ps
`include "pgs_map.svh"
module pgs_vdecode
    import pgs_pkg::*;
(
    // Code in
    input wire logic [3:0] code_i,
    input wire pgs_mode_t mode_i,
    // Target out
    output logic [`PGS_MV_WIDTH-1:0] mv_o,
    output logic active_o
);
    // Table lookup; switch mode leaves the code without effect
    always_comb
    begin
        active_o = (mode_i == PGS_MODE_LDO);
        case (code_i)
            4'h0: mv_o = 13'd4200;
            4'h1: mv_o = 13'd3600;
            4'h2: mv_o = 13'd3300;
            4'h3: mv_o = 13'd3150;
            4'h4: mv_o = 13'd3000;
            4'h5: mv_o = 13'd2850;
            4'h6: mv_o = 13'd2500;
            4'h7: mv_o = 13'd2300;
            4'h8: mv_o = 13'd2100;
            4'h9: mv_o = 13'd1800;
            4'ha: mv_o = 13'd1500;
            4'hb: mv_o = 13'd1400;
            4'hc: mv_o = 13'd1300;
            4'hd: mv_o = 13'd1200;
            4'he: mv_o = 13'd1100;
            default: mv_o = 13'd1000;
        endcase
        if (!active_o)
        begin
            mv_o = '0;
        end
    end
endmodule // pgs_vdecode

// [hw/pgs_bank.sv]
// Power-good status, pin route and regulator 3 voltage registers
// Behaviour
// - The regulator 3 four-bit code maps 0000..1111 to 4.20 V down to 1.00 V in the fixed table.
// - In load-switch mode the regulator 3 code has no effect on the output target.
// - Status bit 3 reads live supply-in-range: above supply-ok and below overvoltage.
// - Status bit 2 reads live battery above the weak threshold.
// - Status bit 1 reads live boost power good, meaningful in standalone fixed-output mode only.
// - Status bit 0 reads live regulator 1 power good, not meaningful in load-switch mode.
// - Route bit 3 puts supply-in-range on the good pin; it resets to a factory value.
// - Route bit 2 puts battery-ok on the good pin; it resets to 0.
// - Route bit 1 puts boost good on the pin, only in boost standalone mode; it resets to 0.
// - Route bit 0 puts regulator 1 good on the pin, not in load-switch mode; factory reset value.
// - Regulator 3 mode bit 0 is linear regulator, 1 is load switch, default regulator.
// - Regulator 1 mode bit 0 is linear regulator, 1 is load switch, default regulator.
`timescale 1ns/10ps
`include "pgs_map.svh"
module pgs_bank
    import pgs_pkg::*;
#(
    // Factory trim values, arbitrary defaults
    parameter logic [3:0] VSEL3_FACTORY = `PGS_VSEL3_RST_DEF,
    parameter logic [3:0] ROUTE_FACTORY = `PGS_ROUTE_RST_DEF
)
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Register access
    input wire pgs_req_t req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    // Analog state
    input wire pgs_good_t good_i,
    input wire logic regulator1_switch_select_i,
    input wire logic regulator3_switch_select_i,
    input wire logic boost_standalone_i,
    // Outputs
    output logic power_good_pin_o,
    output logic [`PGS_MV_WIDTH-1:0] regulator3_target_mv_o,
    output logic regulator3_regulating_o
);
    // Stored fields
    logic [3:0] regulator3_voltage_code_q;
    logic [3:0] route_q;
    // Write strobes decoded from the request
    logic wr_code_w;
    logic wr_route_w;
    // Live status and effective pin routes
    logic [3:0] status_w;
    logic [3:0] route_eff_w;
    logic boost_route_en_w;
    logic reg1_route_en_w;
    // Next values of the registered outputs
    logic power_good_pin_d;
    logic [7:0] rdata_d;
    logic rvalid_d;
    // Decoder results and channel modes
    logic [`PGS_MV_WIDTH-1:0] mv_w;
    logic active_w;
    pgs_mode_t mode1_w;
    pgs_mode_t mode3_w;

    // Modes from the configuration bits
    assign mode1_w = regulator1_switch_select_i ? PGS_MODE_SWITCH : PGS_MODE_LDO;
    assign mode3_w = regulator3_switch_select_i ? PGS_MODE_SWITCH : PGS_MODE_LDO;

    // Write decode; the status address is read-only, so a write there is dropped
    always_comb
    begin
        wr_code_w = 1'b0;
        wr_route_w = 1'b0;
        if (req_i.wr)
        begin
            wr_code_w = (req_i.addr == `PGS_ADDR_VSEL3);
            wr_route_w = (req_i.addr == `PGS_ADDR_ROUTE);
        end
    end

    // Live status image; no storage, so a read sees the level of that cycle
    always_comb
    begin
        status_w = '0;
        status_w[`PGS_BIT_SUPPLY] = good_i.supply;
        status_w[`PGS_BIT_BATT] = good_i.batt;
        status_w[`PGS_BIT_BOOST] = good_i.boost;
        status_w[`PGS_BIT_REG1] = good_i.reg1;
    end

    // Voltage code register
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            regulator3_voltage_code_q <= VSEL3_FACTORY;
        end
        else if (wr_code_w)
        begin
            regulator3_voltage_code_q <= req_i.wdata[`PGS_FIELD_MSB:0];
        end
    end

    // Pin route register; trim can never set the battery and boost route bits at reset
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            route_q <= (ROUTE_FACTORY & `PGS_ROUTE_FIXED_MASK);
        end
        else if (wr_route_w)
        begin
            route_q <= req_i.wdata[`PGS_FIELD_MSB:0];
        end
    end

    // Mode gates for the two conditional routes
    always_comb
    begin
        boost_route_en_w = boost_standalone_i;
        reg1_route_en_w = (mode1_w == PGS_MODE_LDO);
    end

    // Effective routes: a gated route is dropped rather than forcing the pin low
    always_comb
    begin
        route_eff_w = route_q;
        route_eff_w[`PGS_BIT_BOOST] = route_q[`PGS_BIT_BOOST] & boost_route_en_w;
        route_eff_w[`PGS_BIT_REG1] = route_q[`PGS_BIT_REG1] & reg1_route_en_w;
    end

    // Pin level; an empty selection reads as good
    always_comb
    begin
        power_good_pin_d = &(status_w | ~route_eff_w);
    end

    // Pin driven from a flop, low while in reset
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            power_good_pin_o <= 1'b0;
        end
        else
        begin
            power_good_pin_o <= power_good_pin_d;
        end
    end

    // Read mux; unmapped addresses read zero, upper nibble always zero
    always_comb
    begin
        rdata_d = 8'h00;
        case (req_i.addr)
            `PGS_ADDR_VSEL3:
            begin
                rdata_d = {4'h0, regulator3_voltage_code_q};
            end
            `PGS_ADDR_STATUS:
            begin
                rdata_d = {4'h0, status_w};
            end
            `PGS_ADDR_ROUTE:
            begin
                rdata_d = {4'h0, route_q};
            end
            default:
            begin
                rdata_d = 8'h00;
            end
        endcase
    end

    // Read strobe, answered one cycle later
    always_comb
    begin
        rvalid_d = req_i.rd;
    end

    // Read data; refreshed every cycle, so it follows the address even without a read
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            rdata_o <= 8'h00;
        end
        else
        begin
            rdata_o <= rdata_d;
        end
    end

    // Read valid pulse
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            rvalid_o <= 1'b0;
        end
        else
        begin
            rvalid_o <= rvalid_d;
        end
    end

    // Voltage table for regulator 3
    pgs_vdecode u_vdecode (
        .code_i(regulator3_voltage_code_q),
        .mode_i(mode3_w),
        .mv_o(mv_w),
        .active_o(active_w)
    );

    // Registered target; zero in reset so no level is requested before trim loads
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            regulator3_target_mv_o <= '0;
        end
        else
        begin
            regulator3_target_mv_o <= mv_w;
        end
    end

    // Registered regulating flag
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            regulator3_regulating_o <= 1'b0;
        end
        else
        begin
            regulator3_regulating_o <= active_w;
        end
    end
endmodule // pgs_bank

// [sim/pgs_chk_assertions.sv]
// Checker bound to the power-good bank
`timescale 1ns/10ps
module pgs_chk
    import pgs_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Register access
    input wire pgs_req_t req_i,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    // Analog state
    input wire pgs_good_t good_i,
    input wire logic regulator1_switch_select_i,
    input wire logic regulator3_switch_select_i,
    input wire logic boost_standalone_i,
    // Outputs
    input wire logic power_good_pin_o,
    input wire logic [12:0] regulator3_target_mv_o,
    input wire logic regulator3_regulating_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // Request halves of a register access
    sequence s_read_req;
        req_i.rd;
    endsequence
    sequence s_status_addr;
        req_i.addr == 8'h36;
    endsequence
    property p_rv; s_read_req |=> rvalid_o && rdata_o[7:4] == 4'h0; endproperty
    a_rv: assert property (p_rv) else $error("no read valid");
    property p_st; s_status_addr |=> rdata_o == {4'h0, $past(good_i)}; endproperty
    a_st: assert property (p_st) else $error("status");
    property p_hi; rdata_o[7:4] == 4'h0; endproperty
    a_hi: assert property (p_hi) else $error("top bits");
    // Pin low needs a bad source one cycle earlier
    property p_pin; $past(rst_n_i) && !power_good_pin_o |-> $past(good_i) != 4'hf; endproperty
    a_pin: assert property (p_pin) else $error("pin low");
    property p_bst; !boost_standalone_i && good_i == 4'hd |=> power_good_pin_o; endproperty
    a_bst: assert property (p_bst) else $error("boost");
    property p_r1; regulator1_switch_select_i && good_i == 4'he |=> power_good_pin_o; endproperty
    a_r1: assert property (p_r1) else $error("reg1");
    property p_sw;
        regulator3_switch_select_i |=> regulator3_target_mv_o == 13'h0 && !regulator3_regulating_o;
    endproperty
    a_sw: assert property (p_sw) else $error("switch");
    property p_rg; !regulator3_switch_select_i |=> regulator3_regulating_o; endproperty
    a_rg: assert property (p_rg) else $error("ldo");
    // All sources good leaves the pin high whatever the routes
    property p_ok; good_i == 4'hf |=> power_good_pin_o; endproperty
    a_ok: assert property (p_ok) else $error("all good pin low");
endmodule // pgs_chk
bind pgs_bank pgs_chk u_chk (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .req_i(req_i),
    .rdata_o(rdata_o),
    .rvalid_o(rvalid_o),
    .good_i(good_i),
    .regulator1_switch_select_i(regulator1_switch_select_i),
    .regulator3_switch_select_i(regulator3_switch_select_i),
    .boost_standalone_i(boost_standalone_i),
    .power_good_pin_o(power_good_pin_o),
    .regulator3_target_mv_o(regulator3_target_mv_o),
    .regulator3_regulating_o(regulator3_regulating_o)
);

// [sim/pgs_host.sv]
// Host model issuing register requests
`timescale 1ns/10ps
module pgs_host
    import pgs_pkg::*;
(
    // Request to the bank
    output pgs_req_t req_o
);
    // Idle until the first call
    initial req_o = '0;
    // Request held until the next call
    task automatic put(input logic w, r, input logic [7:0] a, d);
        req_o = {w, r, a, d};
    endtask
endmodule // pgs_host

// [sim/tb_power_good_status_and_pin_select.sv]
// Random bench for the power-good bank
`timescale 1ns/10ps
module tb_power_good_status_and_pin_select;
    import pgs_pkg::*;
    logic clk = 0, rn = 0, s1 = 0, s3 = 0, bs = 0, rv, pin, rg;
    logic [7:0] rd, a;
    logic [12:0] mv;
    logic [3:0] vs = 4'h2, rt = 4'h9, ex;
    int n_fail = 0, checked = 0, k;
    int tab[16] = '{4200, 3600, 3300, 3150, 3000, 2850, 2500, 2300, 2100, 1800, 1500, 1400, 1300, 1200, 1100, 1000};
    pgs_req_t req;
    pgs_good_t g = '0;
    pgs_host host (.req_o(req));
    pgs_bank #(.ROUTE_FACTORY(4'hf)) uut (.clk_sys_i(clk), .rst_n_i(rn), .req_i(req), .rdata_o(rd), .rvalid_o(rv),
        .good_i(g), .regulator1_switch_select_i(s1), .regulator3_switch_select_i(s3), .boost_standalone_i(bs),
        .power_good_pin_o(pin), .regulator3_target_mv_o(mv), .regulator3_regulating_o(rg));
    // 10 ns clock
    initial forever #5 clk = ~clk;
    // Count compares, report mismatches
    task automatic chk(input logic [31:0] s, e, input string m);
        checked++;
        if (s !== e)
        begin
            n_fail++;
            $display("MISMATCH %0t %s seen %h expected %h", $time, m, s, e);
        end
    endtask
    task automatic finish_test;
        if (n_fail == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #50us;
        n_fail++;
        finish_test();
    end
    // Reset, then random traffic against the model; route reset keeps only bits 3 and 0
    initial
    begin
        void'($urandom(32'h7b44423c));
        repeat (20) @(negedge clk);
        rn = 1;
        repeat (3000)
        begin
            k = $urandom % 4;
            a = k == 3 ? 8'($urandom) : 8'h35 + 8'(k);
            k = $urandom % 3;
            {s1, s3, bs, g} = 7'($urandom);
            host.put(k == 1, k == 2, a, 8'($urandom));
            @(negedge clk);
            ex = a == 8'h35 ? vs : a == 8'h36 ? g : a == 8'h37 ? rt : 4'h0;
            chk(mv, s3 ? 13'h0 : 13'(tab[vs]), "target");
            chk(rg, {~s3}, "regulating");
            chk(pin, &(g | ~(rt & {2'b11, bs, ~s1})), "pin");
            chk({rv, rd}, {k == 2, 4'h0, ex}, "read");
            if (k == 1 && a == 8'h35) vs = req.wdata[3:0];
            if (k == 1 && a == 8'h37) rt = req.wdata[3:0];
        end
        finish_test();
    end
endmodule // tb_power_good_status_and_pin_select
